// ---- lcp_map.svh ----
// register map, field positions, reset values and timing figures of the load cell chain
// included by the package and the chain; definitions only
`ifndef LCP_MAP_SVH
`define LCP_MAP_SVH
// ======================================================
// timing, in their own units
`define LCP_CLK_HZ 100000000
`define LCP_RATE_LO_DHZ 105000
`define LCP_RATE_HI_DHZ 1055000
`define LCP_OSR 64
`define LCP_INTEG_N 76
`define LCP_AVG_SH 2
`define LCP_FIR_TAPS 64
`define LCP_FIR50_DHZ 500
`define LCP_FIR60_DHZ 600
`define LCP_CAL_MIN 3
`define LCP_DYN_TICK_MS 10
`define LCP_RATIO_FRAC 31
`define LCP_GAIN_FRAC 16
`define LCP_NOTCH_MIN 11'h001
`define LCP_NOTCH_MAX 11'h7d0
// ======================================================
// register byte offsets
`define LCP_REG_CTRL 6'h00
`define LCP_REG_CFG0 6'h04
`define LCP_REG_CFG1 6'h08
`define LCP_REG_NOTCH 6'h0c
`define LCP_REG_DYNT 6'h10
`define LCP_REG_DYND 6'h14
`define LCP_REG_GAIN 6'h18
`define LCP_REG_STAT 6'h1c
`define LCP_REG_WEIGHT 6'h20
// ======================================================
// fields and reset values
`define LCP_CT_MODE 0
`define LCP_CT_RATE 1
`define LCP_CT_CAL_AUTO 2
`define LCP_CT_CAL_TRIG 3
`define LCP_CT_SYNC 4
`define LCP_CT_TS_PDO 5
`define LCP_CT_W 6
`define LCP_CFG_AVG 0
`define LCP_CFG_FILT 1
`define LCP_CFG_SEL_LO 8
`define LCP_CFG_SEL_HI 11
`define LCP_CFG_W 12
`define LCP_CTRL_RST 6'h04
`define LCP_CFG_RST 12'h003
`define LCP_NOTCH_RST 11'h1f4
`define LCP_DYNT_RST 8'h0a
`define LCP_DYND_RST 32'h0000_0010
`define LCP_GAIN_RST 32'h0001_0000
`endif

// ---- lcp_pkg.sv ----
// types shared by the load cell chain
// includes lcp_map.svh but takes no figure from it; enum codes are literal
`include "lcp_map.svh"
package lcp_pkg;
   typedef enum logic [3:0] {
      LCP_SEL_FIR50 = 4'h0,
      LCP_SEL_FIR60 = 4'h1,
      LCP_SEL_IIR1 = 4'h2,
      LCP_SEL_IIR8 = 4'h9,
      LCP_SEL_DYN = 4'ha,
      LCP_SEL_NOTCH = 4'hb
   } lcp_fsel_t;
   typedef enum logic [1:0] {
      LCP_W_IDLE = 2'b00,
      LCP_W_DIV = 2'b01,
      LCP_W_MUL = 2'b10,
      LCP_W_PUSH = 2'b11
   } lcp_wstate_t;
endpackage

// ---- lcp_chain.sv ----
// load cell sample chain: integrator, averager, software filter, weight, process data fifo
// front end presents both channels whenever raw_tick is high; registers over avalon-mm
// What this block does
// R1: reference and differential raw samples are taken on the same strobe.
// R2: differential over reference ratio is scaled into a weight and published.
// R3: order is converter, averager, software filter, weight calculation.
// R4: two selectable converter rates, each from a 64-fold oversampled strobe.
// R5: each converter value sums 76 consecutive raw samples.
// R6: enabled averager outputs the mean of the four latest converter values.
// R7: averager enable is per measuring mode; cleared means bypass unchanged.
// R8: filter is fir or iir; after reset it is on as 50 Hz fir.
// R9: each mode holds its own filter enable and filter selection.
// R10: fir notches at 50 or 60 Hz; higher frequency gives shorter period.
// R11: adjustable notch frequency in 0.1 Hz units, 0.1 to 200 Hz, live.
// R12: master maps the notch output object and selects the adjustable notch.
// R13: iir offers eight low-pass levels, one weakest, eight strongest.
// R14: self-calibration on after reset every three minutes; disable or trigger.
// R15: synced timestamp mode bypasses all software filtering.
// R16: fir results once per conversion period; iir every converter value.
// R17: selection 0 fir50, 1 fir60, 2-9 iir1-8, 10 adaptive, 11 notch.
// R18: adaptive level steps weaker on large change, else stronger, within 1-8.
// R19: iir is y += (x - y) shifted right, shift growing with level.
`timescale 1ns/1ns
`default_nettype none
`include "lcp_map.svh"

module lcp_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   input wire logic clk, // clock
   input wire logic rstn, // sync reset, active low
   input wire logic in_valid, // write request
   output logic in_ready, // room left
   input wire logic [W-1:0] in_data, // write word
   output logic out_valid, // word available
   input wire logic out_ready, // reader takes word
   output logic [W-1:0] out_data, // head word
   output logic [$clog2(D):0] level // words held
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wp_reg;
   logic [AW:0] rp_reg;
   assign level = wp_reg - rp_reg;
   assign in_ready = level != (AW+1)'(D);
   assign out_valid = level != '0;
   assign out_data = mem[rp_reg[AW-1:0]];
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wp_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         if (in_valid && in_ready) wp_reg <= wp_reg + 1'b1;
         if (out_valid && out_ready) rp_reg <= rp_reg + 1'b1;
      end
   end
endmodule // lcp_fifo

module lcp_chain #(
   parameter longint CAL_CYC = longint'(`LCP_CLK_HZ) * 60 * `LCP_CAL_MIN,
   parameter int DYN_TICK_CYC = `LCP_CLK_HZ / 1000 * `LCP_DYN_TICK_MS,
   parameter int FIR50_CYC = `LCP_CLK_HZ * 10 / (`LCP_FIR50_DHZ * `LCP_FIR_TAPS),
   parameter int FIR60_CYC = `LCP_CLK_HZ * 10 / (`LCP_FIR60_DHZ * `LCP_FIR_TAPS),
   parameter int NOTCH_NUM = `LCP_CLK_HZ * 10 / `LCP_FIR_TAPS
) (
   input wire logic clk, // 100 MHz
   input wire logic rstn, // sync reset, active low
   input wire logic [5:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   output logic raw_tick, // modulator-rate sample strobe
   input wire logic [23:0] raw_ref, // reference raw sample
   input wire logic [23:0] raw_diff, // differential raw sample
   output logic cal_start, // self-calibration start pulse
   input wire logic cal_done, // front end finished calibration
   output logic pd_valid, // weight word ready
   input wire logic pd_ready, // fieldbus takes weight
   output logic [31:0] pd_data // weight value
);
   import lcp_pkg::*;
   localparam int RAW_LO_CYC = `LCP_CLK_HZ * 10 / (`LCP_RATE_LO_DHZ * `LCP_OSR);
   localparam int RAW_HI_CYC = `LCP_CLK_HZ * 10 / (`LCP_RATE_HI_DHZ * `LCP_OSR);
   localparam int NW = 48 + `LCP_RATIO_FRAC;

   // ======================================================
   // register slave
   logic ack_reg;
   logic wr_go;
   logic [`LCP_CT_W-1:0] ctrl_reg;
   logic [`LCP_CFG_W-1:0] cfg0_reg;
   logic [`LCP_CFG_W-1:0] cfg1_reg;
   logic [10:0] notch_reg;
   logic [7:0] dynt_reg;
   logic [31:0] dynd_reg;
   logic [31:0] gain_reg;
   logic [31:0] weight_reg;
   logic [31:0] stat;
   logic [`LCP_CFG_W-1:0] cfg;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign wr_go = avs_write && ack_reg;
   always_ff @(posedge clk) begin
      if (!rstn) ack_reg <= 1'b0;
      else ack_reg <= (avs_read || avs_write) && !ack_reg;
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         avs_readdata <= '0;
      end else if (avs_read && !ack_reg) begin
         case (avs_address)
            `LCP_REG_CTRL: avs_readdata <= 32'(ctrl_reg);
            `LCP_REG_CFG0: avs_readdata <= 32'(cfg0_reg);
            `LCP_REG_CFG1: avs_readdata <= 32'(cfg1_reg);
            `LCP_REG_NOTCH: avs_readdata <= 32'(notch_reg);
            `LCP_REG_DYNT: avs_readdata <= 32'(dynt_reg);
            `LCP_REG_DYND: avs_readdata <= dynd_reg;
            `LCP_REG_GAIN: avs_readdata <= gain_reg;
            `LCP_REG_STAT: avs_readdata <= stat;
            `LCP_REG_WEIGHT: avs_readdata <= weight_reg;
            default: avs_readdata <= '0;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_reg <= `LCP_CTRL_RST; // R14
         cfg0_reg <= `LCP_CFG_RST; // R8
         cfg1_reg <= `LCP_CFG_RST;
         notch_reg <= `LCP_NOTCH_RST;
         dynt_reg <= `LCP_DYNT_RST;
         dynd_reg <= `LCP_DYND_RST;
         gain_reg <= `LCP_GAIN_RST;
      end else if (wr_go) begin
         case (avs_address)
            `LCP_REG_CTRL: ctrl_reg <= avs_writedata[`LCP_CT_W-1:0];
            `LCP_REG_CFG0: cfg0_reg <= avs_writedata[`LCP_CFG_W-1:0]; // R9
            `LCP_REG_CFG1: cfg1_reg <= avs_writedata[`LCP_CFG_W-1:0]; // R9
            `LCP_REG_NOTCH: begin
               // out-of-range frequencies clamp to the 0.1..200 Hz span
               if (avs_writedata < `LCP_NOTCH_MIN) notch_reg <= `LCP_NOTCH_MIN; // R11
               else if (avs_writedata > 32'(`LCP_NOTCH_MAX)) notch_reg <= `LCP_NOTCH_MAX; // R11
               else notch_reg <= avs_writedata[10:0];
            end
            `LCP_REG_DYNT: dynt_reg <= avs_writedata[7:0];
            `LCP_REG_DYND: dynd_reg <= avs_writedata;
            `LCP_REG_GAIN: gain_reg <= avs_writedata;
            default: ;
         endcase
      end
   end

   // ======================================================
   // mode selection
   logic sync_on;
   logic avg_en;
   logic filt_en;
   lcp_fsel_t fsel;
   assign cfg = ctrl_reg[`LCP_CT_MODE] ? cfg1_reg : cfg0_reg; // R9
   assign sync_on = ctrl_reg[`LCP_CT_SYNC];
   assign avg_en = cfg[`LCP_CFG_AVG]; // R7
   assign filt_en = cfg[`LCP_CFG_FILT] && !sync_on; // R15
   assign fsel = lcp_fsel_t'(cfg[`LCP_CFG_SEL_HI:`LCP_CFG_SEL_LO]); // R17

   // ======================================================
   // self-calibration
   logic [63:0] cal_cnt_reg;
   logic cal_busy_reg;
   logic cal_go;
   assign cal_go = !cal_busy_reg && ((ctrl_reg[`LCP_CT_CAL_AUTO] && cal_cnt_reg >= 64'(CAL_CYC - 1))
      || (wr_go && avs_address == `LCP_REG_CTRL && avs_writedata[`LCP_CT_CAL_TRIG])); // R14
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cal_cnt_reg <= '0;
         cal_busy_reg <= 1'b0;
         cal_start <= 1'b0;
      end else begin
         cal_start <= cal_go;
         if (cal_go || !ctrl_reg[`LCP_CT_CAL_AUTO]) cal_cnt_reg <= '0;
         else if (!cal_busy_reg) cal_cnt_reg <= cal_cnt_reg + 1'b1;
         if (cal_go) cal_busy_reg <= 1'b1;
         else if (cal_done) cal_busy_reg <= 1'b0;
      end
   end

   // ======================================================
   // modulator strobe and 76-sample integrator
   logic [7:0] raw_cnt_reg;
   logic [6:0] int_n_reg;
   logic signed [31:0] int_r_reg;
   logic signed [31:0] int_d_reg;
   logic signed [31:0] sx_r;
   logic signed [31:0] sx_d;
   logic conv_v_reg;
   logic signed [31:0] conv_r_reg;
   logic signed [31:0] conv_d_reg;
   assign sx_r = {{8{raw_ref[23]}}, raw_ref};
   assign sx_d = {{8{raw_diff[23]}}, raw_diff};
   assign raw_tick = raw_cnt_reg == '0;
   always_ff @(posedge clk) begin
      if (!rstn || raw_tick) begin
         raw_cnt_reg <= ctrl_reg[`LCP_CT_RATE] ? 8'(RAW_HI_CYC - 1) : 8'(RAW_LO_CYC - 1); // R4
      end else begin
         raw_cnt_reg <= raw_cnt_reg - 1'b1;
      end
   end
   // samples taken during calibration are discarded, the run restarts afterwards
   always_ff @(posedge clk) begin
      if (!rstn || cal_busy_reg) begin
         int_n_reg <= '0;
         int_r_reg <= '0;
         int_d_reg <= '0;
         conv_v_reg <= 1'b0;
         conv_r_reg <= '0;
         conv_d_reg <= '0;
      end else begin
         conv_v_reg <= 1'b0;
         if (raw_tick) begin
            if (int_n_reg == 7'(`LCP_INTEG_N - 1)) begin // R5
               conv_r_reg <= int_r_reg + sx_r; // R1
               conv_d_reg <= int_d_reg + sx_d; // R1
               conv_v_reg <= 1'b1;
               int_n_reg <= '0;
               int_r_reg <= '0;
               int_d_reg <= '0;
            end else begin
               int_r_reg <= int_r_reg + sx_r; // R1
               int_d_reg <= int_d_reg + sx_d;
               int_n_reg <= int_n_reg + 1'b1;
            end
         end
      end
   end

   // ======================================================
   // sliding averager over the last four converter values
   logic signed [31:0] hr_reg [3];
   logic signed [31:0] hd_reg [3];
   logic s1_v_reg;
   logic signed [47:0] s1_r_reg;
   logic signed [47:0] s1_d_reg;
   logic signed [33:0] sum_r;
   logic signed [33:0] sum_d;
   assign sum_r = 34'(conv_r_reg) + 34'(hr_reg[0]) + 34'(hr_reg[1]) + 34'(hr_reg[2]);
   assign sum_d = 34'(conv_d_reg) + 34'(hd_reg[0]) + 34'(hd_reg[1]) + 34'(hd_reg[2]);
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hr_reg <= '{default: '0};
         hd_reg <= '{default: '0};
         s1_v_reg <= 1'b0;
         s1_r_reg <= '0;
         s1_d_reg <= '0;
      end else begin
         s1_v_reg <= conv_v_reg; // R3
         if (conv_v_reg) begin
            hr_reg <= '{conv_r_reg, hr_reg[0], hr_reg[1]};
            hd_reg <= '{conv_d_reg, hd_reg[0], hd_reg[1]};
            s1_r_reg <= avg_en ? 48'(sum_r >>> `LCP_AVG_SH) : 48'(conv_r_reg); // R6 R7
            s1_d_reg <= avg_en ? 48'(sum_d >>> `LCP_AVG_SH) : 48'(conv_d_reg); // R6 R7
         end
      end
   end

   // ======================================================
   // iir low-pass and adaptive level
   logic [2:0] dyn_lvl_reg;
   logic [2:0] lvl;
   logic [3:0] sh;
   logic is_iir;
   logic signed [47:0] iir_r_reg;
   logic signed [47:0] iir_d_reg;
   logic [31:0] tick_cnt_reg;
   logic [7:0] ivl_cnt_reg;
   logic signed [47:0] last_d_reg;
   logic signed [47:0] dev;
   assign is_iir = fsel >= LCP_SEL_IIR1 && fsel <= LCP_SEL_DYN; // R17
   assign lvl = fsel == LCP_SEL_DYN ? dyn_lvl_reg : 3'(fsel - LCP_SEL_IIR1); // R13
   assign sh = lvl == '0 ? 4'h1 : {lvl, 1'b0}; // R19
   always_ff @(posedge clk) begin
      if (!rstn) begin
         iir_r_reg <= '0;
         iir_d_reg <= '0;
      end else if (s1_v_reg) begin
         iir_r_reg <= iir_r_reg + ((s1_r_reg - iir_r_reg) >>> sh); // R19
         iir_d_reg <= iir_d_reg + ((s1_d_reg - iir_d_reg) >>> sh); // R19
      end
   end
   assign dev = s1_d_reg > last_d_reg ? s1_d_reg - last_d_reg : last_d_reg - s1_d_reg;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         dyn_lvl_reg <= '1;
         tick_cnt_reg <= '0;
         ivl_cnt_reg <= '0;
         last_d_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg == 32'(DYN_TICK_CYC - 1) ? '0 : tick_cnt_reg + 1'b1;
         if (tick_cnt_reg == 32'(DYN_TICK_CYC - 1)) begin
            if (ivl_cnt_reg + 1'b1 >= dynt_reg) begin // R18
               ivl_cnt_reg <= '0;
               last_d_reg <= s1_d_reg;
               if (dev > 48'(dynd_reg)) begin
                  if (dyn_lvl_reg != '0) dyn_lvl_reg <= dyn_lvl_reg - 1'b1; // R18
               end else if (dyn_lvl_reg != '1) begin
                  dyn_lvl_reg <= dyn_lvl_reg + 1'b1; // R18
               end
            end else begin
               ivl_cnt_reg <= ivl_cnt_reg + 1'b1;
            end
         end
      end
   end

   // ======================================================
   // fir notch: boxcar over one notch period, updated once per conversion period
   // a sum over exactly 1/f has zeros at f and all its multiples
   logic signed [47:0] ring_r [`LCP_FIR_TAPS];
   logic signed [47:0] ring_d [`LCP_FIR_TAPS];
   logic [5:0] idx_reg;
   logic full_reg;
   logic [31:0] per_cnt_reg;
   logic [31:0] per_cyc;
   logic [31:0] notch_cyc_reg;
   logic per_tick;
   logic signed [47:0] sub_r_reg;
   logic signed [47:0] sub_d_reg;
   logic signed [47:0] tot_r_reg;
   logic signed [47:0] tot_d_reg;
   always_ff @(posedge clk) begin
      if (!rstn) notch_cyc_reg <= '0;
      else notch_cyc_reg <= 32'(NOTCH_NUM) / 32'(notch_reg); // R11
   end
   always_comb begin
      case (fsel)
         LCP_SEL_FIR60: per_cyc = 32'(FIR60_CYC); // R10
         LCP_SEL_NOTCH: per_cyc = notch_cyc_reg; // R11
         default: per_cyc = 32'(FIR50_CYC); // R10
      endcase
   end
   assign per_tick = per_cnt_reg + 1'b1 >= per_cyc;
   always_ff @(posedge clk) begin
      if (per_tick) begin
         ring_r[idx_reg] <= sub_r_reg;
         ring_d[idx_reg] <= sub_d_reg;
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         per_cnt_reg <= '0;
         idx_reg <= '0;
         full_reg <= 1'b0;
         sub_r_reg <= '0;
         sub_d_reg <= '0;
         tot_r_reg <= '0;
         tot_d_reg <= '0;
      end else begin
         per_cnt_reg <= per_tick ? '0 : per_cnt_reg + 1'b1;
         if (per_tick) begin
            sub_r_reg <= s1_v_reg ? s1_r_reg : '0;
            sub_d_reg <= s1_v_reg ? s1_d_reg : '0;
            tot_r_reg <= tot_r_reg + sub_r_reg - (full_reg ? ring_r[idx_reg] : '0);
            tot_d_reg <= tot_d_reg + sub_d_reg - (full_reg ? ring_d[idx_reg] : '0);
            idx_reg <= idx_reg + 1'b1;
            if (idx_reg == '1) full_reg <= 1'b1;
         end else if (s1_v_reg) begin
            sub_r_reg <= sub_r_reg + s1_r_reg;
            sub_d_reg <= sub_d_reg + s1_d_reg;
         end
      end
   end

   // ======================================================
   // filter output select
   logic f_v;
   logic signed [47:0] f_r;
   logic signed [47:0] f_d;
   logic f_v_reg;
   always_comb begin
      if (!filt_en) begin // R15
         f_v = s1_v_reg;
         f_r = s1_r_reg;
         f_d = s1_d_reg;
      end else if (is_iir) begin
         f_v = s1_v_reg; // R16
         f_r = iir_r_reg + ((s1_r_reg - iir_r_reg) >>> sh);
         f_d = iir_d_reg + ((s1_d_reg - iir_d_reg) >>> sh);
      end else begin
         f_v = per_tick; // R16
         f_r = tot_r_reg;
         f_d = tot_d_reg;
      end
   end

   // ======================================================
   // weight: ratio by restoring division, then gain
   lcp_wstate_t ws_reg;
   logic pend_reg;
   logic signed [47:0] pr_reg;
   logic signed [47:0] pd_reg;
   logic [NW-1:0] q_reg;
   logic [48:0] rem_reg;
   logic [47:0] den_reg;
   logic neg_reg;
   logic [6:0] it_reg;
   logic [48:0] trial;
   logic signed [31:0] ratio;
   logic signed [63:0] prod;
   logic fifo_ready;
   logic [4:0] fifo_level;
   assign trial = {rem_reg[47:0], q_reg[NW-1]};
   assign ratio = neg_reg ? -$signed(q_reg[31:0]) : $signed(q_reg[31:0]);
   assign prod = 64'(ratio) * 64'(signed'(gain_reg));
   // a value that arrives while the divider is busy replaces the pending one
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pend_reg <= 1'b0;
         pr_reg <= '0;
         pd_reg <= '0;
         f_v_reg <= 1'b0;
      end else begin
         f_v_reg <= f_v;
         if (f_v) begin
            pend_reg <= 1'b1;
            pr_reg <= f_r;
            pd_reg <= f_d;
         end else if (ws_reg == LCP_W_IDLE && fifo_ready) begin
            pend_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ws_reg <= LCP_W_IDLE;
         q_reg <= '0;
         rem_reg <= '0;
         den_reg <= '0;
         neg_reg <= 1'b0;
         it_reg <= '0;
         weight_reg <= '0;
      end else begin
         case (ws_reg)
            LCP_W_IDLE: begin
               // the fifo ready term holds off a new division while the fifo is full
               if (pend_reg && !f_v && fifo_ready) begin
                  neg_reg <= pd_reg[47];
                  q_reg <= NW'(pd_reg[47] ? -pd_reg : pd_reg) << `LCP_RATIO_FRAC; // R2
                  den_reg <= pr_reg[47] || pr_reg == '0 ? '1 : pr_reg;
                  rem_reg <= '0;
                  it_reg <= '0;
                  ws_reg <= LCP_W_DIV;
               end
            end
            LCP_W_DIV: begin
               if (trial >= {1'b0, den_reg}) rem_reg <= trial - {1'b0, den_reg};
               else rem_reg <= trial;
               q_reg <= {q_reg[NW-2:0], trial >= {1'b0, den_reg}};
               it_reg <= it_reg + 1'b1;
               if (it_reg == 7'(NW - 1)) ws_reg <= LCP_W_MUL;
            end
            LCP_W_MUL: begin
               weight_reg <= prod[`LCP_GAIN_FRAC+31:`LCP_GAIN_FRAC]; // R2
               ws_reg <= LCP_W_PUSH;
            end
            LCP_W_PUSH: begin
               if (fifo_ready) ws_reg <= LCP_W_IDLE;
            end
            default: ws_reg <= LCP_W_IDLE;
         endcase
      end
   end

   lcp_fifo #(.W(32), .D(16)) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(ws_reg == LCP_W_PUSH), // R2
      .in_ready(fifo_ready),
      .in_data(weight_reg),
      .out_valid(pd_valid),
      .out_ready(pd_ready),
      .out_data(pd_data),
      .level(fifo_level)
   );

   assign stat = {16'h0000, 3'b000, fifo_level, 1'b0, dyn_lvl_reg, f_v_reg, pend_reg,
      sync_on, cal_busy_reg};
endmodule // lcp_chain
`default_nettype wire

// ---- lcp_asserts.sv ----
// port checker for the load cell chain
// bound to lcp_chain from tb_top; one clock, sync active-low reset
`timescale 1ns/1ns
`default_nettype none
module lcp_asserts #(
   parameter longint CAL_CYC = 2000
) (
   input wire logic clk, // clock
   input wire logic rstn, // reset, low
   input wire logic [5:0] avs_address, // address
   input wire logic avs_read, // read
   input wire logic avs_write, // write
   input wire logic [31:0] avs_readdata, // read data
   input wire logic avs_waitrequest, // stall
   input wire logic raw_tick, // strobe
   input wire logic cal_start, // cal pulse
   input wire logic pd_valid, // word ready
   input wire logic pd_ready, // word taken
   input wire logic [31:0] pd_data // weight
);
   localparam int CAL_W = int'(CAL_CYC) + 10;
   int gap_cnt;
   always_ff @(posedge clk) gap_cnt <= !rstn || cal_start ? 0 : gap_cnt + 1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========
   // properties
   a_one_wait: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait count off");
   a_unmapped_zero: assert property (avs_read && avs_address == 6'h3c && !avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_tick_pulse: assert property (raw_tick |=> !raw_tick [*8])
      else $error("strobe too close");
   a_tick_period: assert property (raw_tick |-> ##[1:148] raw_tick)
      else $error("strobe too late");
   a_cal_spaced: assert property (cal_start |=> !cal_start [*8])
      else $error("cal pulse too long");
   a_cal_first: assert property (gap_cnt <= CAL_W)
      else $error("no auto cal");
   a_pd_hold: assert property (pd_valid && !pd_ready |=> pd_valid && $stable(pd_data))
      else $error("weight word dropped");
   a_pd_empty: assert property ($rose(rstn) |-> !pd_valid)
      else $error("data after reset");
endmodule // lcp_asserts
`default_nettype wire

// ---- lcp_fe_model.sv ----
// front end model: two channels and the calibration answer
// driven by the chain's strobe and cal pulse
`timescale 1ns/1ns
`default_nettype none
module lcp_fe_model #(
   parameter logic [23:0] REF = 24'h100000,
   parameter logic [23:0] DIFF = 24'h080000
) (
   input wire logic clk, // clock
   input wire logic rstn, // reset, low
   input wire logic raw_tick, // strobe
   input wire logic cal_start, // cal request
   output logic [23:0] raw_ref, // reference
   output logic [23:0] raw_diff, // differential
   output logic cal_done // cal finished
);
   logic [2:0] cnt_reg;
   // lines are not held off the strobe, so show the inverse there
   assign raw_ref = raw_tick ? REF : ~REF;
   assign raw_diff = raw_tick ? DIFF : ~DIFF;
   always_ff @(posedge clk) begin
      if (!rstn) cnt_reg <= 3'h0;
      else if (cal_start) cnt_reg <= 3'h5;
      else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
   end
   assign cal_done = cnt_reg == 3'h1;
endmodule // lcp_fe_model
`default_nettype wire

// ---- tb_top.sv ----
// bench for the load cell chain: avalon tasks and process data pops
// front end model on the raw side, short counts by parameter
`timescale 1ns/1ns
`default_nettype none
`include "lcp_map.svh"
module tb_top;
   logic clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, pd_ready = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, pd_data, rd;
   logic avs_waitrequest, raw_tick, cal_start, cal_done, pd_valid;
   logic [23:0] raw_ref, raw_diff;
   logic [5:0] ra [8] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h3c};
   logic [31:0] rv [8] = '{32'h4, 32'h3, 32'h3, 32'h1f4, 32'ha, 32'h10, 32'h10000, 32'h0};
   int miscompares = 0, n_tests = 0, n_cal = 0, i, c0;
   always #5 clk = ~clk;
   always @(posedge clk) if (cal_start === 1'b1) n_cal++;
   lcp_chain #(.CAL_CYC(2000), .DYN_TICK_CYC(50), .FIR50_CYC(200), .FIR60_CYC(170), .NOTCH_NUM(20000)) lcp_chain_i (
      .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .raw_tick(raw_tick), .raw_ref(raw_ref), .raw_diff(raw_diff), .cal_start(cal_start),
      .cal_done(cal_done), .pd_valid(pd_valid), .pd_ready(pd_ready), .pd_data(pd_data));
   lcp_fe_model lcp_fe_model_i (.clk(clk), .rstn(rstn), .raw_tick(raw_tick), .cal_start(cal_start),
      .raw_ref(raw_ref), .raw_diff(raw_diff), .cal_done(cal_done));
   // ==========
   // tasks
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !w;
      avs_write <= w;
      do begin @(posedge clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
      if (avs_waitrequest !== 1'b0) begin miscompares++; close_out; end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pop(input logic [31:0] e);
      int k;
      k = 0;
      do begin @(posedge clk); k++; end while (pd_valid !== 1'b1 && k < 3000);
      if (pd_valid !== 1'b1) begin miscompares++; close_out; end
      chk(pd_data, e);
      pd_ready <= 1'b1;
      @(posedge clk);
      pd_ready <= 1'b0;
   endtask
   // ==========
   // sequence
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 8; i++) begin bus(1'b0, ra[i], 32'h0); chk(rd, rv[i]); end
      bus(1'b1, 6'h3c, 32'hffffffff);
      bus(1'b0, 6'h3c, 32'h0);
      chk(rd, 32'h0);
      $display("reset values done");
      for (i = 0; i < 12; i++) begin
         bus(1'b1, `LCP_REG_CFG1, {20'h0, i[3:0], 8'h02});
         bus(1'b0, `LCP_REG_CFG1, 32'h0);
         chk(rd, {20'h0, i[3:0], 8'h02});
      end
      bus(1'b0, `LCP_REG_CFG0, 32'h0);
      chk(rd, 32'h3);
      bus(1'b1, `LCP_REG_NOTCH, 32'h0);
      bus(1'b0, `LCP_REG_NOTCH, 32'h0);
      chk(rd, 32'h1);
      bus(1'b1, `LCP_REG_NOTCH, 32'hbb8);
      bus(1'b0, `LCP_REG_NOTCH, 32'h0);
      chk(rd, 32'h7d0);
      bus(1'b1, `LCP_REG_CTRL, 32'h14);
      bus(1'b0, `LCP_REG_STAT, 32'h0);
      chk({31'h0, rd[1]}, 32'h1);
      $display("config done");
      c0 = n_cal;
      bus(1'b1, `LCP_REG_CTRL, 32'h0e);
      for (i = 0; i < 20 && n_cal == c0; i++) @(posedge clk);
      chk({31'h0, n_cal > c0}, 32'h1);
      $display("cal trigger done");
      bus(1'b1, `LCP_REG_CTRL, 32'h06);
      bus(1'b1, `LCP_REG_CFG0, 32'h0);
      pd_ready <= 1'b1;
      repeat (3000) @(posedge clk);
      pd_ready <= 1'b0;
      // fifo must fill to its depth, then 17 pops must each read the same weight
      for (i = 0; i < 12000; i++) begin
         bus(1'b0, `LCP_REG_STAT, 32'h0);
         if (rd[12:8] == 5'h10) break;
      end
      chk({27'h0, rd[12:8]}, 32'h10);
      for (i = 0; i < 17; i++) pop(32'h40000000);
      $display("weight path done");
      bus(1'b1, `LCP_REG_CTRL, 32'h07);
      bus(1'b1, `LCP_REG_CFG1, 32'h102);
      repeat (1200) @(posedge clk);
      bus(1'b0, `LCP_REG_STAT, 32'h0);
      chk({31'h0, rd[12:8] > 5'h4}, 32'h1);
      for (i = 0; i < 4; i++) pop(32'h40000000);
      $display("fir mode done");
      close_out;
   end
endmodule // tb_top
bind lcp_chain lcp_asserts #(.CAL_CYC(CAL_CYC)) lcp_asserts_i (.clk(clk), .rstn(rstn),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .raw_tick(raw_tick), .cal_start(cal_start), .pd_valid(pd_valid),
   .pd_ready(pd_ready), .pd_data(pd_data));
`default_nettype wire
